/* File: swc_sleep_wakeup_control.sv */
//////////////////////////////////////////////////////////////////////////////////////////////
module swc_sleep_wakeup_control
   import swc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // core instruction and exception signals
   input  wire logic        waitIntrInstr,
   input  wire logic        waitEventInstr,
   input  wire logic        lastHandlerDone,
   input  wire logic        excEntryReady,
   input  wire logic        irqAbovePriority,
   input  wire logic        interruptMaskBit,
   input  wire logic        allFaultBlockBit,
   input  wire logic        newPendingIrq,
   // event sources and debug
   input  wire logic        extEventIn,
   input  wire logic        sendEventIn,
   input  wire logic        debugConnected,
   // core and power control
   output logic             coreStall,
   output logic             continueExec,
   output logic             handlerDefer,
   output logic             procClkHalt,
   output logic             sysClkHalt,
   output logic             pllOff,
   output logic             flashOff,
   output logic             detectorArmed,
   output logic             powerDownAllow
);

   //////////////////////////////////////////////////////////////////////////////////////////
   // state declarations
   swc_state_t state_r;
   swc_state_t state_nxt;
   logic [2:0] ctrl_r;
   logic       eventLatch_r;
   logic       eventLatch_nxt;
   logic       byEvent_r;
   logic       byEvent_nxt;
   logic       defer_r;
   logic       defer_nxt;
   logic       detWake_r;
   logic       detWake_nxt;
   logic [7:0] wakeCnt_r;
   logic [7:0] wakeCnt_nxt;
   logic       ready_r;
   logic       slvErr_r;
   logic [31:0] rdata_r;
   logic       stall_r;
   logic       cont_r;
   logic       procHalt_r;
   logic       sysHalt_r;
   logic       pllOff_r;
   logic       flashOff_r;
   logic       armed_r;
   logic       pdAllow_r;

   //////////////////////////////////////////////////////////////////////////////////////////
   // apb decode: one access cycle, ready rises on the first access edge
   wire apbSetup   = psel & ~penable;
   wire apbDone    = psel & penable & ready_r;
   wire hitCtrl    = (paddr == CTRL_OFFSET);
   wire hitStatus  = (paddr == STATUS_OFFSET);
   wire hitAny     = hitCtrl | hitStatus;
   wire ctrlWrite  = apbDone & pwrite & hitCtrl;

   // software controls; the event latch has no address at all
   wire exitSleep  = ctrl_r[CTRL_EXIT_BIT];
   wire deepSel    = ctrl_r[CTRL_DEEP_BIT];
   wire pendEvent  = ctrl_r[CTRL_PENDEV_BIT];
   // a debugger wins over deep select for the detector only, so the detector never hides a halted core
   wire detActive  = deepSel & ~debugConnected;

   // status word shows the controller's own state; latch deliberately absent
   wire [31:0] statusWord = {25'h0, defer_r, detActive, byEvent_r, state_r};

   //////////////////////////////////////////////////////////////////////////////////////////
   // wake and event conditions
   wire maskedWake = interruptMaskBit & ~allFaultBlockBit & irqAbovePriority;
   wire excWake    = excEntryReady | maskedWake;
   wire pendEv     = pendEvent & newPendingIrq;
   wire anyEvent   = extEventIn | sendEventIn | pendEv;
   wire evWake     = excWake | anyEvent;
   wire isRun      = (state_r == ST_RUN);
   wire isSleep    = (state_r == ST_LIGHT) | (state_r == ST_DEEP);
   wire wakeNow    = byEvent_r ? evWake : excWake;
   wire wfiSleep   = waitIntrInstr & ~excWake;
   wire wfeSleep   = waitEventInstr & ~eventLatch_r;
   wire wfeSkip    = waitEventInstr & eventLatch_r;
   wire exitReq    = lastHandlerDone & exitSleep;
   wire sleepReq   = isRun & (wfiSleep | wfeSleep | exitReq);
   swc_state_t sleepState;
   assign sleepState = deepSel ? ST_DEEP : ST_LIGHT;

   //////////////////////////////////////////////////////////////////////////////////////////
   // next-state logic of the sleep controller
   always_comb begin
      state_nxt   = state_r;
      byEvent_nxt = byEvent_r;
      detWake_nxt = detWake_r;
      wakeCnt_nxt = wakeCnt_r;
      case (state_r)
         ST_RUN: begin
            if (sleepReq) begin
               state_nxt   = sleepState;
               byEvent_nxt = wfeSleep & ~waitIntrInstr;
               detWake_nxt = deepSel & detActive;
            end
         end
         ST_LIGHT, ST_DEEP: begin
            // a detector wake must restore state before the core resumes
            if (wakeNow && detWake_r && detActive) begin
               state_nxt   = ST_WAKE;
               wakeCnt_nxt = WAKE_CNT_LOAD;
            end else if (wakeNow) begin
               state_nxt = ST_RUN;
            end
         end
         ST_WAKE: begin
            if (wakeCnt_r == 8'h00) begin
               state_nxt = ST_RUN;
            end else begin
               wakeCnt_nxt = wakeCnt_r - 8'h01;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // latch: an event that wakes an event-wait sleep is consumed, otherwise stored;
   // a new event in the same cycle as a wfe clear wins
   always_comb begin
      eventLatch_nxt = eventLatch_r;
      if (wfeSkip && isRun) begin
         eventLatch_nxt = 1'b0;
      end
      if (anyEvent && !(isSleep && byEvent_r)) begin
         eventLatch_nxt = 1'b1;
      end
   end

   // handler deferral after a masked wake, released when the mask clears
   always_comb begin
      defer_nxt = defer_r;
      if (isSleep && wakeNow && maskedWake && !excEntryReady) begin
         defer_nxt = 1'b1;
      end else if (!interruptMaskBit) begin
         defer_nxt = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // controller registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_r      <= ST_RUN;
         eventLatch_r <= 1'b0;
         byEvent_r    <= 1'b0;
         defer_r      <= 1'b0;
         detWake_r    <= 1'b0;
         wakeCnt_r    <= 8'h00;
      end else begin
         state_r      <= state_nxt;
         eventLatch_r <= eventLatch_nxt;
         byEvent_r    <= byEvent_nxt;
         defer_r      <= defer_nxt;
         detWake_r    <= detWake_nxt;
         wakeCnt_r    <= wakeCnt_nxt;
      end
   end

   // clock, power and core outputs, all registered; all but continueExec decoded from the next state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stall_r    <= 1'b0;
         cont_r     <= 1'b0;
         procHalt_r <= 1'b0;
         sysHalt_r  <= 1'b0;
         pllOff_r   <= 1'b0;
         flashOff_r <= 1'b0;
         armed_r    <= 1'b0;
         pdAllow_r  <= 1'b0;
      end else begin
         stall_r    <= (state_nxt != ST_RUN);
         cont_r     <= wfeSkip & isRun;
         procHalt_r <= (state_nxt == ST_LIGHT) | (state_nxt == ST_DEEP);
         sysHalt_r  <= (state_nxt == ST_DEEP);
         pllOff_r   <= (state_nxt == ST_DEEP);
         flashOff_r <= (state_nxt == ST_DEEP);
         armed_r    <= detActive & (state_nxt == ST_DEEP);
         pdAllow_r  <= detActive & (state_nxt == ST_DEEP) & detWake_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // apb slave: control write, status read, unmapped answers with an error
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r   <= CTRL_RESET;
         ready_r  <= 1'b0;
         slvErr_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
      end else begin
         ready_r  <= apbSetup;
         slvErr_r <= apbSetup & ~hitAny;
         rdata_r  <= (apbSetup & ~pwrite & hitCtrl) ? {29'h0, ctrl_r} :
                     (apbSetup & ~pwrite & hitStatus) ? statusWord : 32'h0000_0000;
         if (ctrlWrite) begin
            ctrl_r <= pwdata[2:0];
         end
      end
   end

   assign prdata         = rdata_r;
   assign pready         = ready_r;
   assign pslverr        = slvErr_r;
   assign coreStall      = stall_r;
   assign continueExec   = cont_r;
   assign handlerDefer   = defer_r;
   assign procClkHalt    = procHalt_r;
   assign sysClkHalt     = sysHalt_r;
   assign pllOff         = pllOff_r;
   assign flashOff       = flashOff_r;
   assign detectorArmed  = armed_r;
   assign powerDownAllow = pdAllow_r;

   //////////////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_deep_sel;
      @(posedge sys_clk) disable iff (!rstn)
      (isRun && sleepReq) |=> (deepSel ? state_r == ST_DEEP : state_r == ST_LIGHT);
   endproperty
   a_deep_sel: assert property (p_deep_sel) else $error("wrong sleep level");

   property p_wfi_wake_true;
      @(posedge sys_clk) disable iff (!rstn)
      (isRun && waitIntrInstr && excWake && !waitEventInstr && !exitReq) |=> isRun;
   endproperty
   a_wfi_wake_true: assert property (p_wfi_wake_true) else $error("wfi slept on wake");

   property p_wfe_skip;
      @(posedge sys_clk) disable iff (!rstn)
      (isRun && wfeSkip && !anyEvent && !waitIntrInstr && !exitReq)
         |=> (!eventLatch_r && isRun && continueExec);
   endproperty
   a_wfe_skip: assert property (p_wfe_skip) else $error("wfe latch not consumed");

   property p_event_sets;
      @(posedge sys_clk) disable iff (!rstn)
      (extEventIn && !(isSleep && byEvent_r)) |=> eventLatch_r;
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event lost");

   property p_exc_only;
      @(posedge sys_clk) disable iff (!rstn)
      (isSleep && !byEvent_r && !excWake) |=> (state_r == $past(state_r));
   endproperty
   a_exc_only: assert property (p_exc_only) else $error("woke without exception");

   property p_ev_wake;
      @(posedge sys_clk) disable iff (!rstn)
      (isSleep && byEvent_r && sendEventIn && !detWake_r) |=> isRun;
   endproperty
   a_ev_wake: assert property (p_ev_wake) else $error("send-event did not wake");

   property p_det_gate;
      @(posedge sys_clk) disable iff (!rstn)
      detectorArmed |-> ($past(deepSel) && !$past(debugConnected));
   endproperty
   a_det_gate: assert property (p_det_gate) else $error("detector armed wrongly");

   property p_restore;
      @(posedge sys_clk) disable iff (!rstn)
      (isSleep && wakeNow && detWake_r && detActive) |=> (state_r == ST_WAKE) [*8];
   endproperty
   a_restore: assert property (p_restore) else $error("restore too short");

   property p_deep_power;
      @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_DEEP) |-> (procClkHalt && sysClkHalt && pllOff && flashOff);
   endproperty
   a_deep_power: assert property (p_deep_power) else $error("deep outputs split");

   property p_light_halt;
      @(posedge sys_clk) disable iff (!rstn)
      (state_r == ST_LIGHT) |-> (procClkHalt && !sysClkHalt && !pllOff && !flashOff);
   endproperty
   a_light_halt: assert property (p_light_halt) else $error("light halts wrong");

   property p_pend_event;
      @(posedge sys_clk) disable iff (!rstn)
      (isSleep && byEvent_r && pendEvent && newPendingIrq && !detWake_r) |=> isRun;
   endproperty
   a_pend_event: assert property (p_pend_event) else $error("pending irq no wake");

   property p_ext_wake;
      @(posedge sys_clk) disable iff (!rstn)
      (isSleep && byEvent_r && extEventIn && !detWake_r) |=> isRun;
   endproperty
   a_ext_wake: assert property (p_ext_wake) else $error("ext event no wake");

   property p_debug_off;
      @(posedge sys_clk) disable iff (!rstn)
      debugConnected |=> (!detectorArmed && !powerDownAllow);
   endproperty
   a_debug_off: assert property (p_debug_off) else $error("detector on with debugger");

   property p_defer_clear;
      @(posedge sys_clk) disable iff (!rstn)
      (handlerDefer && !interruptMaskBit) |=> !handlerDefer;
   endproperty
   a_defer_clear: assert property (p_defer_clear) else $error("defer held");

endmodule

/* File: swc_pkg.sv */
package swc_pkg;
   // apb register map, byte addresses of aligned words
   localparam logic [7:0] CTRL_OFFSET        = 8'h00;
   localparam logic [7:0] STATUS_OFFSET      = 8'h04;
   // control register field positions
   localparam int         CTRL_EXIT_BIT      = 0;
   localparam int         CTRL_DEEP_BIT      = 1;
   localparam int         CTRL_PENDEV_BIT    = 2;
   localparam logic [2:0] CTRL_RESET         = 3'h0;
   // status register field positions
   localparam int         STAT_STATE_LSB     = 0;
   localparam int         STAT_BYEVENT_BIT   = 4;
   localparam int         STAT_DETECTOR_BIT  = 5;
   localparam int         STAT_DEFER_BIT     = 6;
   // wake restore time after a detector wake, and its cycle count
   localparam int         CLK_PERIOD_PS      = 4000;
   localparam int         WAKE_RESTORE_NS    = 40;
   localparam int         WAKE_CYCLES        = (WAKE_RESTORE_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
   localparam logic [7:0] WAKE_CNT_LOAD      = 8'(WAKE_CYCLES - 1);
   // sleep controller states, one-hot
   typedef enum logic [3:0] {
      ST_RUN   = 4'h1,
      ST_LIGHT = 4'h2,
      ST_DEEP  = 4'h4,
      ST_WAKE  = 4'h8
   } swc_state_t;
endpackage

/* File: swc_pmu_model.sv */
module swc_pmu_model (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // bench requests and the block's power hint
   input  wire logic       irqReq,
   input  wire logic       maskedReq,
   input  wire logic       powerDownAllow,
   // interrupt source and tick timer
   output logic            excEntryReady,
   output logic            irqAbovePriority,
   output logic      [7:0] tickCount
);
   timeunit 1ns;
   timeprecision 1ps;
   //////////////////////////////////////////////////////////////////////////////////
   // sources answer a cycle late, as through a synchroniser, so no same-edge wake
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         excEntryReady    <= 1'b0;
         irqAbovePriority <= 1'b0;
      end else begin
         excEntryReady    <= irqReq;
         irqAbovePriority <= irqReq | maskedReq;
      end
   end
   // tick timer loses power while the core may be powered down
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tickCount <= 8'h00;
      end else if (!powerDownAllow) begin
         tickCount <= tickCount + 8'h01;
      end
   end
endmodule

/* File: tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import swc_pkg::*;
   logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, tickCount, tick0;
   logic [31:0] pwdata, prdata;
   logic [5:0]  pulseV;
   logic        irqReq, maskedReq, interruptMaskBit, allFaultBlockBit, debugConnected;
   logic        excEntryReady, irqAbovePriority, coreStall, continueExec, handlerDefer;
   logic        procClkHalt, sysClkHalt, pllOff, flashOff, detectorArmed, powerDownAllow;
   logic [8:0]  coreV, snap;
   int          err_total, n_compared, n;
   assign coreV = {powerDownAllow, flashOff, pllOff, handlerDefer, detectorArmed,
                   sysClkHalt, procClkHalt, continueExec, coreStall};
   //////////////////////////////////////////////////////////////////////////////////
   swc_sleep_wakeup_control DUT (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .waitIntrInstr(pulseV[0]),
      .waitEventInstr(pulseV[1]), .lastHandlerDone(pulseV[2]), .excEntryReady,
      .irqAbovePriority, .interruptMaskBit, .allFaultBlockBit, .newPendingIrq(pulseV[3]),
      .extEventIn(pulseV[4]), .sendEventIn(pulseV[5]), .debugConnected, .coreStall,
      .continueExec, .handlerDefer, .procClkHalt, .sysClkHalt, .pllOff, .flashOff,
      .detectorArmed, .powerDownAllow);
   swc_pmu_model PMU (.sys_clk, .rstn, .irqReq, .maskedReq, .powerDownAllow,
      .excEntryReady, .irqAbovePriority, .tickCount);
   //////////////////////////////////////////////////////////////////////////////////
   // compare helpers and the closing task
   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cv(input string nm, input logic [8:0] exp, got);
      chk(nm, {23'h0, exp}, {23'h0, got});
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, exp,
                      input logic eErr);
      @(posedge sys_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pslverr", {31'h0, eErr}, {31'h0, pslverr});
      if (!w) chk("prdata", exp, prdata);
   endtask
   // one-cycle core pulse; snap holds the outputs right after the sampling edge
   task automatic pulse(input int b);
      @(posedge sys_clk);
      pulseV <= 6'(1 << b);
      @(posedge sys_clk);
      pulseV <= 6'h00;
      #1 snap = coreV;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   // interrupt source levels, passed through the partner's extra cycle
   task automatic lvl(input logic i, m);
      @(posedge sys_clk);
      irqReq    <= i;
      maskedReq <= m;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   //////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      report_and_stop;
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pulseV} = '0;
      {irqReq, maskedReq, interruptMaskBit, allFaultBlockBit, debugConnected} = '0;
      {err_total, n_compared} = '0;
      rstn = 1'b0;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      // reset values, stored width, read-only status, unmapped word
      apb(0, CTRL_OFFSET, 0, {29'h0, CTRL_RESET}, 0);
      apb(1, CTRL_OFFSET, 32'hFFFFFFFF, 0, 0);
      apb(0, CTRL_OFFSET, 0, 32'h7, 0);
      apb(1, STATUS_OFFSET, 32'hFF, 0, 0);
      apb(0, STATUS_OFFSET, 0, 32'h21, 0);
      apb(0, 8'h08, 0, 0, 1);
      apb(1, CTRL_OFFSET, 0, 0, 0);
      // interrupt wait: only a sufficient exception wakes, an event is latched
      pulse(0); cv("wfi light", 9'h005, snap);
      apb(0, STATUS_OFFSET, 0, 32'h2, 0);
      pulse(3); cv("pending irq", 9'h005, coreV);
      pulse(4); cv("ext event", 9'h005, coreV);
      lvl(1, 0); cv("wfi wake", 9'h000, coreV);
      pulse(0); cv("wfi awake", 9'h000, snap);
      lvl(0, 0);
      // event wait with the latch set, then clear
      pulse(1); cv("wfe latched", 9'h002, snap);
      pulse(1); cv("wfe sleep", 9'h005, snap);
      apb(0, STATUS_OFFSET, 0, 32'h12, 0);
      pulse(5); cv("sev wake", 9'h000, coreV);
      pulse(5);
      pulse(1); cv("sev latched", 9'h002, snap);
      pulse(1);
      pulse(4); cv("ext wake", 9'h000, coreV);
      pulse(1); cv("event consumed", 9'h005, snap);
      lvl(1, 0); cv("exc wake wfe", 9'h000, coreV);
      lvl(0, 0);
      // pending interrupt as an event
      apb(1, CTRL_OFFSET, 32'h4, 0, 0);
      pulse(1);
      pulse(3); cv("pend event", 9'h000, coreV);
      // sleep after the last handler, on and off
      apb(1, CTRL_OFFSET, 32'h1, 0, 0);
      pulse(2); cv("exit sleep", 9'h005, snap);
      lvl(1, 0);
      lvl(0, 0);
      apb(1, CTRL_OFFSET, 32'h0, 0, 0);
      pulse(2); cv("exit no sleep", 9'h000, snap);
      // masked interrupt wakes, handler held until the mask clears
      @(posedge sys_clk);
      interruptMaskBit <= 1'b1;
      pulse(0);
      lvl(0, 1); cv("masked wake", 9'h020, coreV);
      @(posedge sys_clk);
      interruptMaskBit <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 cv("defer done", 9'h000, coreV);
      lvl(0, 0);
      // fault mask set too: a masked interrupt must not wake
      @(posedge sys_clk);
      {interruptMaskBit, allFaultBlockBit} <= 2'b11;
      pulse(0);
      lvl(0, 1); cv("fault mask", 9'h005, coreV);
      lvl(1, 0); cv("fault mask wake", 9'h000, coreV);
      @(posedge sys_clk);
      {interruptMaskBit, allFaultBlockBit} <= 2'b00;
      lvl(0, 0);
      // deep level with the detector, then with a debugger attached
      apb(1, CTRL_OFFSET, 32'h2, 0, 0);
      pulse(0); cv("deep", 9'h1DD, snap);
      tick0 = tickCount;
      repeat (5) @(posedge sys_clk);
      #1 chk("tick", {24'h0, tick0}, {24'h0, tickCount});
      lvl(1, 0); cv("restore", 9'h001, coreV);
      for (n = 1; coreStall === 1'b1 && n < 40; n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk("restore len", 1, 32'(n >= WAKE_CYCLES - 1 && n <= WAKE_CYCLES + 1));
      lvl(0, 0);
      @(posedge sys_clk);
      debugConnected <= 1'b1;
      pulse(0); cv("deep debug", 9'h0CD, snap);
      lvl(1, 0); cv("debug wake", 9'h000, coreV);
      lvl(0, 0);
      report_and_stop;
   end
endmodule
